// ==== hw/barsf_top.sv ====
// Operation
// - input clock above about 200 kHz: detector low, oscillator off, external clock used.
// - input clock below about 200 kHz: detector high, internal oscillator enabled.
// - modulator samples at master clock divided by 64.
// - decimation by fourth-order sinc filter, four zeros per notch.
// - low-pass corner 2.4 Hz slow, 19 Hz fast at nominal clock.
// - slow rate puts nulls at every multiple of 10 Hz.
// - nominal clock gives 10 results per second slow, 80 fast.
// - result period is 491520 clocks slow, 61440 clocks fast.
// - channel select toggle forces ready/data high until settled.
// - ready/data goes low only once fully settled data exist.
// - first result after a channel change is already settled.
// - result is 24-bit two's complement.
// - results clip at 7FFFFF and 800000; zero input gives 000000.
// - new result pulls ready/data low until the host starts shifting.
// - shift clock rising edges present msb first, one bit per edge.
`timescale 1ns/1ps
`default_nettype none
module barsf_top
#(
   parameter int DET_WINDOW = barsf_pkg::DET_WINDOW_CYC,
   parameter int DECIM_SLOW = barsf_pkg::DECIM_SLOW,
   parameter int DECIM_FAST = barsf_pkg::DECIM_FAST
)
(
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   input  wire logic                       clock_in_crystal_a_i,
   input  wire logic                       mod_bit_i,
   input  wire logic                       rate_select_i,
   input  wire logic                       channel_select_lsb_i,
   input  wire logic                       channel_select_msb_i,
   input  wire logic                       sclk_i,
   output logic                            ready_data_out_o,
   output logic                            clk_detect_o,
   output logic                            osc_enable_o,
   output logic                            mod_tick_o,
   input  wire logic [barsf_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]                reg_wdata_i,
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   output logic [31:0]                     reg_rdata_o,
   output logic                            irq_o
);
   import barsf_pkg::*;

   localparam int DW_W    = $clog2(DET_WINDOW + 1);
   // edges expected in one window at the threshold frequency
   localparam int DET_THR = (DET_WINDOW * CLK_PERIOD_NS * DET_FREQ_KHZ) / 1000000;
   localparam logic [DW_W-1:0] DW_LAST = DW_W'(DET_WINDOW - 1);
   localparam logic [DW_W-1:0] DW_THR  = DW_W'(DET_THR);
   localparam logic [5:0]      MOD_LAST = 6'(MOD_DIV - 1);
   localparam logic [2:0]      SET_LAST = 3'(SETTLE_OUTPUTS - 1);

   // clock presence detector
   logic            ck_q_ff;
   logic            ck_edge;
   logic [DW_W-1:0] win_cnt_ff;
   logic [DW_W-1:0] edge_cnt_ff;
   logic            clk_detect_ff;

   // conversion
   logic [5:0]      mod_cnt_ff;
   logic            mod_tick;
   logic [1:0]      chan_q_ff;
   logic            rate_q_ff;
   logic            restart;
   logic            res_valid;
   logic [RES_W-1:0] res_data;
   logic [2:0]      settle_cnt_ff;
   logic            fresh_ff;
   logic            publish;

   // serial output
   barsf_state_t    state_ff;
   logic [RES_W-1:0] data_ff;
   logic [RES_W-1:0] shreg_ff;
   logic [4:0]      bit_cnt_ff;
   logic            dout_ff;
   logic            sclk_q_ff;
   logic            sclk_rise;

   // registers
   logic [EVT_W-1:0] status_ff;
   logic [EVT_W-1:0] mask_ff;
   logic [EVT_W-1:0] evt;
   logic [31:0]      rdata_ff;

   assign ck_edge = clock_in_crystal_a_i && !ck_q_ff;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ck_q_ff     <= 1'b0;
         win_cnt_ff  <= '0;
         edge_cnt_ff <= '0;
      end
      else
      begin
         ck_q_ff <= clock_in_crystal_a_i;
         if (win_cnt_ff == DW_LAST)
         begin
            win_cnt_ff  <= '0;
            edge_cnt_ff <= '0;
         end
         else
         begin
            win_cnt_ff <= win_cnt_ff + DW_W'(1);
            if (ck_edge && edge_cnt_ff != DW_LAST)
               edge_cnt_ff <= edge_cnt_ff + DW_W'(1);
         end
      end
   end

   // decision only at window end, so a stopped pin reads as slow within two windows
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         clk_detect_ff <= 1'b1;
      else if (win_cnt_ff == DW_LAST)
      begin
         if (edge_cnt_ff > DW_THR)
            clk_detect_ff <= 1'b0;
         else
            clk_detect_ff <= 1'b1;
      end
   end

   assign clk_detect_o = clk_detect_ff;
   assign osc_enable_o = clk_detect_ff;

   // modulator sample strobe
   assign mod_tick   = (mod_cnt_ff == MOD_LAST);
   assign mod_tick_o = mod_tick;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         mod_cnt_ff <= '0;
      else
         mod_cnt_ff <= mod_cnt_ff + 6'(1);
   end

   // any channel select change restarts the filter; rate change too, so data are never mixed
   assign restart = ({channel_select_msb_i, channel_select_lsb_i} != chan_q_ff)
                    || (rate_select_i != rate_q_ff);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         chan_q_ff <= 2'b00;
         rate_q_ff <= 1'b0;
      end
      else
      begin
         chan_q_ff <= {channel_select_msb_i, channel_select_lsb_i};
         rate_q_ff <= rate_select_i;
      end
   end

   barsf_sinc4
   #(
      .DECIM_SLOW (DECIM_SLOW),
      .DECIM_FAST (DECIM_FAST)
   )
   u_sinc4
   (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .clear_i     (restart),
      .sample_i    (mod_tick),
      .bit_i       (mod_bit_i),
      .rate_fast_i (rate_select_i),
      .valid_o     (res_valid),
      .data_o      (res_data)
   );

   // a cleared sinc4 needs four full periods; earlier outputs are withheld
   assign publish = res_valid && !restart && (settle_cnt_ff == SET_LAST);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         settle_cnt_ff <= '0;
         fresh_ff      <= 1'b1;
      end
      else if (restart)
      begin
         settle_cnt_ff <= '0;
         fresh_ff      <= 1'b1;
      end
      else if (res_valid)
      begin
         if (settle_cnt_ff != SET_LAST)
            settle_cnt_ff <= settle_cnt_ff + 3'(1);
         else
            fresh_ff <= 1'b0;
      end
   end

   assign sclk_rise = sclk_i && !sclk_q_ff;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         sclk_q_ff <= 1'b0;
      else
         sclk_q_ff <= sclk_i;
   end

   // output word holder
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         data_ff <= CODE_ZERO;
      else if (publish)
         data_ff <= res_data;
   end

   // ready/data state: restart beats a new result, a new result beats a shift edge
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_ff   <= ST_IDLE;
         dout_ff    <= 1'b1;
         shreg_ff   <= '0;
         bit_cnt_ff <= '0;
      end
      else if (restart)
      begin
         state_ff <= ST_IDLE;
         dout_ff  <= 1'b1;
      end
      else if (publish)
      begin
         state_ff <= ST_READY;
         dout_ff  <= 1'b0;
      end
      else if (sclk_rise)
      begin
         case (state_ff)
            ST_READY:
            begin
               state_ff   <= ST_SHIFT;
               dout_ff    <= data_ff[RES_W-1];
               shreg_ff   <= {data_ff[RES_W-2:0], 1'b0};
               bit_cnt_ff <= 5'd1;
            end
            ST_SHIFT:
            begin
               if (bit_cnt_ff == 5'(RES_W))
               begin
                  state_ff <= ST_IDLE;
                  dout_ff  <= 1'b1;
               end
               else
               begin
                  dout_ff    <= shreg_ff[RES_W-1];
                  shreg_ff   <= {shreg_ff[RES_W-2:0], 1'b0};
                  bit_cnt_ff <= bit_cnt_ff + 5'd1;
               end
            end
            default:
               state_ff <= ST_IDLE;
         endcase
      end
   end

   assign ready_data_out_o = dout_ff;

   // events
   always_comb
   begin
      evt              = '0;
      evt[EVT_RESULT]  = publish;
      evt[EVT_SETTLED] = publish && fresh_ff;
      evt[EVT_OVERRUN] = publish && (state_ff != ST_IDLE);
   end

   // write-one-to-clear; an event in the same cycle wins
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         status_ff <= '0;
      else if (reg_wr_i && reg_addr_i == REG_STATUS)
         status_ff <= (status_ff & ~reg_wdata_i[EVT_W-1:0]) | evt;
      else
         status_ff <= status_ff | evt;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         mask_ff <= MASK_RST;
      else if (reg_wr_i && reg_addr_i == REG_MASK)
         mask_ff <= reg_wdata_i[EVT_W-1:0];
   end

   assign irq_o = |(status_ff & mask_ff);

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_ff <= '0;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            REG_STATUS: rdata_ff <= {29'h0, status_ff};
            REG_MASK:   rdata_ff <= {29'h0, mask_ff};
            REG_RESULT: rdata_ff <= {8'h00, data_ff};
            REG_STATE:  rdata_ff <= {22'h0, clk_detect_ff, rate_q_ff, chan_q_ff,
                                     settle_cnt_ff, state_ff, dout_ff};
            default:    rdata_ff <= '0;
         endcase
      end
      else
         rdata_ff <= '0;
   end

   assign reg_rdata_o = rdata_ff;

endmodule
`default_nettype wire

// ==== hw/barsf_pkg.sv ====
`default_nettype none
package barsf_pkg;

   // master clock
   localparam int CLK_PERIOD_NS   = 10;

   // modulator and decimation (in modulator samples per result)
   localparam int MOD_DIV         = 64;
   localparam int DECIM_SLOW      = 7680;
   localparam int DECIM_FAST      = 960;
   localparam int SETTLE_OUTPUTS  = 4;
   localparam int RES_W           = 24;

   // clock presence detector
   localparam int DET_WINDOW_NS   = 100000;
   localparam int DET_FREQ_KHZ    = 200;
   localparam int DET_WINDOW_CYC  = DET_WINDOW_NS / CLK_PERIOD_NS;

   // result clipping codes
   localparam logic [23:0] CODE_POS_FS = 24'h7F_FFFF;
   localparam logic [23:0] CODE_NEG_FS = 24'h80_0000;
   localparam logic [23:0] CODE_ZERO   = 24'h00_0000;

   // register port
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  REG_STATUS  = 8'h00;
   localparam logic [7:0]  REG_MASK    = 8'h04;
   localparam logic [7:0]  REG_RESULT  = 8'h08;
   localparam logic [7:0]  REG_STATE   = 8'h0C;
   localparam int          EVT_W       = 3;
   localparam int          EVT_RESULT  = 0;
   localparam int          EVT_SETTLED = 1;
   localparam int          EVT_OVERRUN = 2;
   localparam logic [2:0]  MASK_RST    = 3'h0;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READY = 2'b01,
      ST_SHIFT = 2'b11
   } barsf_state_t;

endpackage
`default_nettype wire

// ==== hw/barsf_sinc4.sv ====
`timescale 1ns/1ps
`default_nettype none
module barsf_sinc4
#(
   parameter int DECIM_SLOW = 7680,
   parameter int DECIM_FAST = 960
)
(
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   input  wire logic                     clear_i,
   input  wire logic                     sample_i,
   input  wire logic                     bit_i,
   input  wire logic                     rate_fast_i,
   output logic                          valid_o,
   output logic [barsf_pkg::RES_W-1:0]   data_o
);
   import barsf_pkg::*;

   localparam int LG_S  = $clog2(DECIM_SLOW);
   localparam int LG_F  = $clog2(DECIM_FAST);
   // small decimations still need room for a full-scale word and its sign
   localparam int ACC_W = (4 * LG_S + 3 > RES_W + 3) ? 4 * LG_S + 3 : RES_W + 3;
   localparam int CNT_W = LG_S + 1;
   // full scale lands well above 2^23, up to 2^24, so clipping is reachable at both rates
   localparam int SH_S  = 4 * LG_S - RES_W;
   localparam int SH_F  = 4 * LG_F - RES_W;
   // short filters scale up, long ones down; never a negative shift count
   localparam int RS_S  = (SH_S > 0) ? SH_S : 0;
   localparam int LS_S  = (SH_S < 0) ? -SH_S : 0;
   localparam int RS_F  = (SH_F > 0) ? SH_F : 0;
   localparam int LS_F  = (SH_F < 0) ? -SH_F : 0;
   localparam logic [CNT_W-1:0] R_S = CNT_W'(DECIM_SLOW - 1);
   localparam logic [CNT_W-1:0] R_F = CNT_W'(DECIM_FAST - 1);

   logic [ACC_W-1:0] integ_ff [4];
   logic [ACC_W-1:0] dly_ff   [4];
   logic [ACC_W-1:0] comb     [5];
   logic [ACC_W-1:0] x;
   logic [CNT_W-1:0] dec_cnt_ff;
   logic             dec_end;
   logic signed [ACC_W-1:0] scaled;

   // modulator bit as +1 / -1; integrators wrap modulo 2^ACC_W on purpose
   assign x       = bit_i ? ACC_W'(1) : {ACC_W{1'b1}};
   assign dec_end = sample_i && (dec_cnt_ff == (rate_fast_i ? R_F : R_S));
   // last stage after this sample's update, so the fourth output holds no pre-clear input
   assign comb[0] = integ_ff[3] + integ_ff[2];

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         dec_cnt_ff <= '0;
      else if (clear_i || dec_end)
         dec_cnt_ff <= '0;
      else if (sample_i)
         dec_cnt_ff <= dec_cnt_ff + CNT_W'(1);
   end

   generate
      for (genvar k = 0; k < 4; k++)
      begin : g_stage
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               integ_ff[k] <= '0;
            else if (clear_i)
               integ_ff[k] <= '0;
            else if (sample_i)
               integ_ff[k] <= integ_ff[k] + ((k == 0) ? x : integ_ff[(k == 0) ? 0 : k-1]);
         end
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               dly_ff[k] <= '0;
            else if (clear_i)
               dly_ff[k] <= '0;
            else if (dec_end)
               dly_ff[k] <= comb[k];
         end
         assign comb[k+1] = comb[k] - dly_ff[k];
      end
   endgenerate

   // rate select changes the decimation and so the corner and notch spacing
   assign scaled = rate_fast_i ? (($signed(comb[4]) <<< LS_F) >>> RS_F)
                               : (($signed(comb[4]) <<< LS_S) >>> RS_S);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         valid_o <= 1'b0;
         data_o  <= CODE_ZERO;
      end
      else
      begin
         valid_o <= dec_end && !clear_i;
         if (dec_end)
         begin
            if (scaled > $signed(ACC_W'(2**(RES_W-1) - 1)))
               data_o <= CODE_POS_FS;
            else if (scaled < -$signed(ACC_W'(2**(RES_W-1))))
               data_o <= CODE_NEG_FS;
            else
               data_o <= scaled[RES_W-1:0];
         end
      end
   end

endmodule
`default_nettype wire

// ==== dv/barsf_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module barsf_properties
   import barsf_pkg::*;
#(
   parameter int DECIM_FAST = 960
)
(
   input wire logic              clk_i,
   input wire logic              rstn_i,
   input wire logic              rate_select_i,
   input wire logic              channel_select_lsb_i,
   input wire logic              channel_select_msb_i,
   input wire logic              sclk_i,
   input wire logic              reg_rd_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0]       reg_rdata_o,
   input wire logic              ready_data_out_o,
   input wire logic              clk_detect_o,
   input wire logic              osc_enable_o,
   input wire logic              mod_tick_o
);
   localparam int GAP_MIN = 192 * DECIM_FAST;
   logic [2:0]  sel;
   logic [2:0]  sel_ff;
   logic [19:0] gap_ff;
   assign sel = {rate_select_i, channel_select_msb_i, channel_select_lsb_i};

   // saturates so a long run never wraps into a false early result
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sel_ff <= 3'h0;
         gap_ff <= 20'h0_0000;
      end
      else
      begin
         sel_ff <= sel;
         if (sel != sel_ff)
            gap_ff <= 20'h0_0000;
         else if (gap_ff != 20'hF_FFFF)
            gap_ff <= gap_ff + 20'h0_0001;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_sel_move;
      !$stable(sel);
   endsequence
   sequence s_idle_low;
      !ready_data_out_o && !sclk_i && $stable(sel);
   endsequence

   AST_OSC_MATCH: assert property (osc_enable_o == clk_detect_o)
      else $error("oscillator enable differs from detect");
   AST_DET_STEADY: assert property ($changed(clk_detect_o) |=> $stable(clk_detect_o) [*8])
      else $error("detect output chatters");
   AST_TICK_PERIOD: assert property (mod_tick_o |-> ##64 mod_tick_o)
      else $error("modulator tick period wrong");
   AST_TICK_GAP: assert property (mod_tick_o |=> !mod_tick_o [*8])
      else $error("modulator tick too close");
   AST_SEL_FORCE: assert property (s_sel_move |=> ready_data_out_o)
      else $error("ready line not forced high on select change");
   AST_SETTLE_GAP: assert property (!ready_data_out_o |-> gap_ff >= GAP_MIN)
      else $error("ready line low before settling");
   AST_READY_HOLD: assert property (s_idle_low |=> !ready_data_out_o)
      else $error("ready line released without shift clock");
   AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside read cycle");
   AST_HOLE_READ: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_RESULT_WIDTH: assert property (reg_rd_i && reg_addr_i == REG_RESULT |=> reg_rdata_o[31:24] == 8'h00)
      else $error("result upper byte not zero");
endmodule

bind barsf_top barsf_properties #(.DECIM_FAST(DECIM_FAST)) u_barsf_properties
(
   .clk_i(clk_i), .rstn_i(rstn_i), .rate_select_i(rate_select_i),
   .channel_select_lsb_i(channel_select_lsb_i), .channel_select_msb_i(channel_select_msb_i),
   .sclk_i(sclk_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .ready_data_out_o(ready_data_out_o), .clk_detect_o(clk_detect_o),
   .osc_enable_o(osc_enable_o), .mod_tick_o(mod_tick_o)
);
`default_nettype wire

// ==== dv/barsf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module barsf_host
(
   input  wire logic   clk_i,
   input  wire logic   go_i,
   input  wire logic   ready_data_out_i,
   output logic        sclk_o,
   output logic        busy_o,
   output logic [23:0] word_o
);
   initial
   begin
      sclk_o = 1'b0;
      busy_o = 1'b0;
      word_o = 24'h00_0000;
   end
   // shift clock stands low outside a read; 25th edge parks the line high
   always @(posedge clk_i)
   begin
      if (go_i && ready_data_out_i === 1'b0)
      begin
         busy_o <= 1'b1;
         for (int i = 0; i < 25; i++)
         begin
            sclk_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            sclk_o <= 1'b0;
            if (i < 24)
               word_o[23 - i] <= ready_data_out_i;
            repeat (2) @(posedge clk_i);
         end
         busy_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== dv/barsf_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module barsf_top_test;
   import barsf_pkg::*;
   localparam int DS = 16;
   localparam int DF = 4;
   logic        clk_i = 1'b0, rstn_i = 1'b0, ck_in = 1'b0, ck_run = 1'b0, rate = 1'b1;
   logic        alt = 1'b0, go = 1'b0, r_wr = 1'b0, r_rd = 1'b0;
   logic [1:0]  ch = 2'b00, mode = 2'd0;
   logic [7:0]  r_addr = 8'h00;
   logic [31:0] r_wdata = 32'h0000_0000;
   logic        mod_bit, sclk, ready, det, osc, tick, irq, busy;
   logic [31:0] r_rdata;
   logic [23:0] word;
   int          n_fail = 0;
   int          samples_checked = 0;

   assign mod_bit = (mode == 2'd2) ? alt : mode[0];
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (tick) alt <= ~alt;
   always @(posedge clk_i) ck_in <= ck_run & ~ck_in;

   barsf_top #(.DET_WINDOW(500), .DECIM_SLOW(DS), .DECIM_FAST(DF)) u_barsf_top
   (
      .clk_i(clk_i), .rstn_i(rstn_i), .clock_in_crystal_a_i(ck_in), .mod_bit_i(mod_bit),
      .rate_select_i(rate), .channel_select_lsb_i(ch[0]), .channel_select_msb_i(ch[1]),
      .sclk_i(sclk), .ready_data_out_o(ready), .clk_detect_o(det), .osc_enable_o(osc),
      .mod_tick_o(tick), .reg_addr_i(r_addr), .reg_wdata_i(r_wdata), .reg_wr_i(r_wr),
      .reg_rd_i(r_rd), .reg_rdata_o(r_rdata), .irq_o(irq)
   );
   barsf_host u_barsf_host
   (
      .clk_i(clk_i), .go_i(go), .ready_data_out_i(ready), .sclk_o(sclk), .busy_o(busy),
      .word_o(word)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      r_addr <= a;
      r_wdata <= d;
      r_wr <= 1'b1;
      @(posedge clk_i);
      r_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      r_addr <= a;
      r_rd <= 1'b1;
      @(posedge clk_i);
      r_rd <= 1'b0;
      @(posedge clk_i);
      d = r_rdata;
   endtask

   // which: 0 watches the ready line, 1 the host busy flag
   task automatic await(input bit which, input logic v, inout int n);
      while ((which ? busy : ready) !== v && n < 9000)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic t_conv(input logic r, input logic [1:0] c, input logic [1:0] m,
                         input logic pre, input logic [23:0] exp);
      int d;
      int n;
      int p;
      d = r ? DF : DS;
      n = 0;
      p = 0;
      go <= 1'b0;
      rate <= r;
      mode <= m;
      if (pre)
      begin
         ch <= c ^ 2'b01;
         repeat (128 * d) @(posedge clk_i);
      end
      ch <= c;
      repeat (2) @(posedge clk_i);
      await(1'b0, 1'b0, n);
      // sample phase after the clear moves the first result by up to one tick
      check("settle", 32'(n >= 256 * d - 64 && n <= 256 * d + 4), 32'h1);
      go <= 1'b1;
      await(1'b1, 1'b1, p);
      // one read only; a held go would start a second one on the next result
      go <= 1'b0;
      await(1'b1, 1'b0, p);
      await(1'b0, 1'b0, p);
      check("period", 32'(p), 32'(64 * d));
      check("word", 32'(word), 32'(exp));
   endtask

   // input step with no pin change; call right after a result so the drain read ends in time
   task automatic t_step(input logic [1:0] m, input logic [23:0] exp);
      int p;
      p = 0;
      go <= 1'b1;
      await(1'b1, 1'b1, p);
      await(1'b1, 1'b0, p);
      mode <= m;
      repeat (5)
      begin
         await(1'b1, 1'b1, p);
         await(1'b1, 1'b0, p);
      end
      go <= 1'b0;
      check("step", 32'(word), 32'(exp));
   endtask

   task automatic t_regs(input logic [23:0] exp);
      logic [31:0] d;
      reg_rd(REG_MASK, d);
      check("mask", d, 32'h0000_0000);
      reg_rd(REG_STATUS, d);
      check("status", d, 32'h0000_0003);
      check("irq masked", 32'(irq), 32'h0000_0000);
      reg_wr(REG_MASK, 32'h0000_0001);
      @(posedge clk_i);
      check("irq set", 32'(irq), 32'h0000_0001);
      reg_wr(REG_STATUS, 32'h0000_0007);
      @(posedge clk_i);
      check("irq clear", 32'(irq), 32'h0000_0000);
      reg_rd(REG_RESULT, d);
      check("result", d, {8'h00, exp});
      reg_rd(8'h10, d);
      check("hole", d, 32'h0000_0000);
      reg_wr(REG_MASK, 32'h0000_0000);
   endtask

   task automatic t_clkdet();
      ck_run <= 1'b1;
      repeat (1100) @(posedge clk_i);
      check("fast input", 32'({det, osc}), 32'h0000_0000);
      ck_run <= 1'b0;
      repeat (1100) @(posedge clk_i);
      check("slow input", 32'({det, osc}), 32'h0000_0003);
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      check("reset", 32'({ready, det, osc, irq}), 32'h0000_000E);
      check("reset rdata", r_rdata, 32'h0000_0000);
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_conv(1'b1, 2'b01, 2'd1, 1'b0, 24'h7F_FFFF);
      t_regs(24'h7F_FFFF);
      t_step(2'd2, 24'h00_0000);
      t_conv(1'b1, 2'b10, 2'd0, 1'b0, 24'h80_0000);
      t_conv(1'b1, 2'b11, 2'd2, 1'b0, 24'h00_0000);
      t_conv(1'b0, 2'b00, 2'd1, 1'b1, 24'h7F_FFFF);
      t_clkdet();
      complete_run();
   end

   // whole sequence needs roughly 15k cycles
   initial
   begin
      #400_000;
      n_fail++;
      complete_run();
   end
endmodule
`default_nettype wire
